// file: ps_defines.svh
// Offsets, field positions, reset values and timing constants of the programmable stage
`ifndef PS_DEFINES_SVH
`define PS_DEFINES_SVH
`define PS_CLK_NS 25
`define PS_PROG_CYCLE_NS 5000000
`define PS_DELTA_WIN_NS 20000000
`define PS_DLY_MAX 360000
`define PS_FRAC_DIV 1000000
`define PS_RATIO_FRAC 16
`define PS_MULT_FRAC 16
`define PS_A_CTRL 5'h00
`define PS_A_MODE 5'h01
`define PS_A_OPDLY 5'h02
`define PS_A_RELDLY 5'h03
`define PS_A_BLIM 5'h04
`define PS_A_MULT0 5'h05
`define PS_A_PICK0 5'h08
`define PS_A_HYST0 5'h0b
`define PS_A_STATUS 5'h10
`define PS_A_TREM 5'h11
`define PS_A_SCALED0 5'h12
`define PS_A_RATIO0 5'h15
`define PS_A_RCALC 5'h18
`define PS_CTRL_CNT_LSB 0
`define PS_MODE_FLD_W 4
`define PS_STAT_BLK_BIT 4
`define PS_STAT_PICK_BIT 5
`define PS_CTRL_RST 32'h0000_0001
`define PS_MODE_RST 32'h0000_0000
`define PS_MULT_RST 32'h0001_0000
`define PS_PICK_RST 32'h0000_0064
`define PS_HYST_RST 32'h0000_7530
`define PS_OPDLY_RST 32'h0000_0008
`define PS_RELDLY_RST 32'h0000_000c
`define PS_BLIM_RST 32'h8000_0000
`endif

// file: ps_pkg.sv
// Types shared by the programmable stage files
`default_nettype none
package ps_pkg;
   typedef enum logic [1:0] {
      PS_NORMAL = 2'b00,
      PS_START = 2'b01,
      PS_TRIP = 2'b11,
      PS_BLOCKED = 2'b10
   } ps_state_e;
   typedef enum logic [2:0] {
      PS_OVER = 3'h0,
      PS_OVER_ABS = 3'h1,
      PS_UNDER = 3'h2,
      PS_UNDER_ABS = 3'h3,
      PS_DREL = 3'h4,
      PS_DREL_ABS = 3'h5,
      PS_DVAL = 3'h6,
      PS_DVAL_ABS = 3'h7
   } ps_mode_e;
endpackage
`default_nettype wire

// file: ps_compare.sv
// One magnitude comparator with hysteresis, blocking limit and 20 ms change modes
`include "ps_defines.svh"
`default_nettype none
module ps_compare import ps_pkg::*; #(
   parameter int W = 32
) (
   input wire logic [2:0] i_mode,
   input wire logic signed [W-1:0] i_val,
   input wire logic signed [W-1:0] i_old,
   input wire logic signed [W-1:0] i_pick,
   input wire logic signed [W-1:0] i_hyst,
   input wire logic signed [W-1:0] i_blim,
   input wire logic i_active,
   output logic o_cond
);
   localparam int XW = 2 * W;

   // Scales a by b parts per million; hysteresis and relative pick-up share it
   function automatic logic signed [XW-1:0] frac(input logic signed [XW-1:0] a,
                                                 input logic signed [XW-1:0] b);
      logic signed [2*XW-1:0] prod;
      prod = a * b;
      return XW'(prod / `PS_FRAC_DIV);
   endfunction

   function automatic logic signed [XW-1:0] mag(input logic signed [XW-1:0] a);
      return (a < 0) ? -a : a;
   endfunction

   wire logic signed [XW-1:0] v = XW'(i_val);
   wire logic signed [XW-1:0] o = XW'(i_old);
   wire logic signed [XW-1:0] p = XW'(i_pick);
   wire logic signed [XW-1:0] d = v - o;
   wire logic signed [XW-1:0] thr_rel = frac(mag(o), p);
   wire logic pick_neg = (i_pick < 0);

   logic signed [XW-1:0] x;
   logic signed [XW-1:0] t;
   logic under;
   logic inhibit;

   always_comb begin
      x = v;
      t = p;
      under = 1'b0;
      inhibit = 1'b0;
      case (ps_mode_e'(i_mode))
         PS_OVER: x = v;
         PS_OVER_ABS: x = mag(v);
         PS_UNDER: begin
            under = 1'b1;
            inhibit = (v < XW'(i_blim));
         end
         PS_UNDER_ABS: begin
            x = mag(v);
            under = 1'b1;
            inhibit = (mag(v) < XW'(i_blim));
         end
         PS_DREL: begin
            x = d;
            t = thr_rel;
            under = pick_neg;
         end
         PS_DREL_ABS: begin
            x = mag(d);
            t = frac(mag(o), mag(p));
         end
         PS_DVAL: begin
            x = d;
            under = pick_neg;
         end
         PS_DVAL_ABS: begin
            x = mag(d);
            t = mag(p);
         end
         default: x = v;
      endcase
   end

   // Hysteresis widens the band only once the condition is already held
   wire logic signed [XW-1:0] h = i_active ? frac(mag(t), XW'(i_hyst)) : '0;
   wire logic hit_over = (x > t - h);
   wire logic hit_under = (x < t + h);
   assign o_cond = (under ? hit_under : hit_over) & ~inhibit;
endmodule // ps_compare
`default_nettype wire

// file: ps_stage.sv
// Programmable threshold stage: register port, program cycle, comparators, timers
// Summary of operation
// - One to three measurements are selected, each compared to its own pick-up.
// - Each measurement is scaled by its own multiplier; scaled value is readable.
// - Ratios of each measurement and calculated magnitude to pick-up are readable.
// - Pick-up levels are signed, 0.0001 resolution, default 0.01.
// - Each pick-up has a release hysteresis in 0.0001 percent steps, default 3 percent.
// - Each magnitude picks one of eight comparator modes, default plain over.
// - Over mode: signed value above pick-up.
// - Absolute over mode: magnitude of value above pick-up.
// - Under mode: value below pick-up, inactive below the blocking limit.
// - Absolute under mode: magnitude below pick-up, suppressed under blocking limit.
// - Signed relative change over 20 ms beyond pick-up percent, direction-dependent.
// - Relative change over 20 ms beyond pick-up percent, either direction.
// - Signed change over 20 ms beyond pick-up value, direction-dependent.
// - Change over 20 ms beyond pick-up value, either direction.
// - Operate delay in 5 ms steps up to 1800 s, default 0.04 s.
// - Release delay applies when pick-up clears, default 0.06 s.
// - State reads as normal, start, trip or blocked.
// - Remaining time to trip is readable while a fault is timed.
// - Blocking input is sampled at the start of each program cycle.
// - Pick-up while unblocked asserts start and starts operate timing.
// - Pick-up while blocked asserts blocked, no start or trip; a stage already in trip keeps trip asserted until the release delay ends.
// - Blocking after start clears start and runs release handling.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`include "ps_defines.svh"
`default_nettype none
module ps_stage import ps_pkg::*; #(
   parameter int W = 32,
   parameter int PROG_CYCLES = `PS_PROG_CYCLE_NS / `PS_CLK_NS
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_addr,
   input wire logic [W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [W-1:0] o_rdata,
   input wire logic signed [W-1:0] i_meas_1,
   input wire logic signed [W-1:0] i_meas_2,
   input wire logic signed [W-1:0] i_meas_3,
   input wire logic i_block,
   output logic o_start,
   output logic o_trip,
   output logic o_blocked,
   output logic o_prog_tick
);
   localparam int NCH = 3;
   localparam int DEPTH = `PS_DELTA_WIN_NS / `PS_PROG_CYCLE_NS;
   localparam int DW = $clog2(`PS_DLY_MAX + 1);
   localparam int CW = $clog2(PROG_CYCLES);
   localparam logic [DW-1:0] DLY_MAX = DW'(`PS_DLY_MAX);

   generate
      if (W < 24 || W > 32) begin : g_bad_w
         $error("ps_stage: W must lie in 24..32");
      end
      if (PROG_CYCLES < 2) begin : g_bad_cyc
         $error("ps_stage: PROG_CYCLES must be at least 2");
      end
   endgenerate

   function automatic logic [DW-1:0] clamp_dly(input logic [W-1:0] v);
      return (v > W'(`PS_DLY_MAX)) ? DLY_MAX : v[DW-1:0];
   endfunction

   // Q16.16 quotient; a zero pick-up reads as ratio zero instead of dividing
   function automatic logic signed [W-1:0] ratio(input logic signed [W-1:0] v,
                                                 input logic signed [W-1:0] p);
      logic signed [2*W-1:0] num;
      num = (2*W)'(v) <<< `PS_RATIO_FRAC;
      return (p == 0) ? '0 : W'(num / (2*W)'(p));
   endfunction

   function automatic logic signed [W-1:0] absv(input logic signed [W-1:0] v);
      return (v < 0) ? -v : v;
   endfunction

   // Reset release through two flops
   logic rst_q1;
   logic nrst;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_q1 <= 1'b0;
         nrst <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         nrst <= rst_q1;
      end
   end

   // Program cycle divider
   logic [CW-1:0] div_cnt;
   logic tick;
   always_ff @(posedge i_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == CW'(PROG_CYCLES - 1));
         div_cnt <= (div_cnt == CW'(PROG_CYCLES - 1)) ? '0 : div_cnt + 1'b1;
      end
   end
   assign o_prog_tick = tick;

   // Setting registers
   logic [1:0] meas_cnt;
   logic [3*`PS_MODE_FLD_W-1:0] mode_reg;
   logic [DW-1:0] op_dly;
   logic [DW-1:0] rel_dly;
   logic signed [W-1:0] blim;
   logic signed [W-1:0] mult [NCH];
   logic signed [W-1:0] pick [NCH];
   logic signed [W-1:0] hyst [NCH];

   wire logic [4:0] mult_off = i_addr - `PS_A_MULT0;
   wire logic [4:0] pick_off = i_addr - `PS_A_PICK0;
   wire logic [4:0] hyst_off = i_addr - `PS_A_HYST0;
   wire logic wr_mult = i_wr && (mult_off < 5'(NCH));
   wire logic wr_pick = i_wr && (pick_off < 5'(NCH));
   wire logic wr_hyst = i_wr && (hyst_off < 5'(NCH));
   wire logic [1:0] cnt_wr = i_wdata[`PS_CTRL_CNT_LSB +: 2];
   wire logic cnt_ok = (cnt_wr != 2'h0);

   always_ff @(posedge i_clk or negedge nrst) begin
      if (!nrst) begin
         meas_cnt <= 2'(`PS_CTRL_RST);
         mode_reg <= (3*`PS_MODE_FLD_W)'(`PS_MODE_RST);
         op_dly <= DW'(`PS_OPDLY_RST);
         rel_dly <= DW'(`PS_RELDLY_RST);
         blim <= W'(`PS_BLIM_RST);
         for (int i = 0; i < NCH; i++) begin
            mult[i] <= W'(`PS_MULT_RST);
            pick[i] <= W'(`PS_PICK_RST);
            hyst[i] <= W'(`PS_HYST_RST);
         end
      end else begin
         if (i_wr && i_addr == `PS_A_CTRL && cnt_ok) meas_cnt <= cnt_wr;
         if (i_wr && i_addr == `PS_A_MODE) mode_reg <= i_wdata[3*`PS_MODE_FLD_W-1:0];
         if (i_wr && i_addr == `PS_A_OPDLY) op_dly <= clamp_dly(i_wdata);
         if (i_wr && i_addr == `PS_A_RELDLY) rel_dly <= clamp_dly(i_wdata);
         if (i_wr && i_addr == `PS_A_BLIM) blim <= i_wdata;
         if (wr_mult) mult[mult_off[1:0]] <= i_wdata;
         if (wr_pick) pick[pick_off[1:0]] <= i_wdata;
         if (wr_hyst) hyst[hyst_off[1:0]] <= i_wdata;
      end
   end

   // Scaling, comparison and 20 ms history
   wire logic signed [W-1:0] meas [NCH];
   assign meas[0] = i_meas_1;
   assign meas[1] = i_meas_2;
   assign meas[2] = i_meas_3;

   logic signed [W-1:0] hist [NCH][DEPTH];
   logic signed [W-1:0] scaled [NCH];
   logic signed [W-1:0] ratio_q [NCH];
   logic signed [W-1:0] ratio_calc;
   logic [NCH-1:0] cond_q;
   wire logic signed [W-1:0] scaled_now [NCH];
   wire logic [NCH-1:0] cond_now;
   wire logic [NCH-1:0] ch_en;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         wire logic signed [2*W-1:0] prod = meas[g] * mult[g];
         assign scaled_now[g] = prod[W-1+`PS_MULT_FRAC:`PS_MULT_FRAC];
         assign ch_en[g] = (meas_cnt > 2'(g));
         ps_compare #(.W(W)) u_cmp (
            .i_mode(mode_reg[g*`PS_MODE_FLD_W +: 3]),
            .i_val(scaled_now[g]),
            .i_old(hist[g][DEPTH-1]),
            .i_pick(pick[g]),
            .i_hyst(hyst[g]),
            .i_blim(blim),
            .i_active(cond_q[g]),
            .o_cond(cond_now[g])
         );
      end
   endgenerate

   // Calculated magnitude: largest absolute scaled value among the selected inputs
   wire logic signed [W-1:0] abs01 = (absv(scaled_now[1]) > absv(scaled_now[0]) && ch_en[1])
                                     ? absv(scaled_now[1]) : absv(scaled_now[0]);
   wire logic signed [W-1:0] calc_mag = (absv(scaled_now[2]) > abs01 && ch_en[2])
                                        ? absv(scaled_now[2]) : abs01;

   always_ff @(posedge i_clk or negedge nrst) begin
      if (!nrst) begin
         cond_q <= '0;
         ratio_calc <= '0;
         for (int i = 0; i < NCH; i++) begin
            scaled[i] <= '0;
            ratio_q[i] <= '0;
            for (int k = 0; k < DEPTH; k++) hist[i][k] <= '0;
         end
      end else if (tick) begin
         cond_q <= cond_now & ch_en;
         ratio_calc <= ratio(calc_mag, pick[0]);
         for (int i = 0; i < NCH; i++) begin
            scaled[i] <= scaled_now[i];
            ratio_q[i] <= ratio(scaled_now[i], pick[i]);
            hist[i][0] <= scaled_now[i];
            for (int k = 1; k < DEPTH; k++) hist[i][k] <= hist[i][k-1];
         end
      end
   end

   // Stage sequencing, one step per program cycle
   wire logic pick_up = |(cond_now & ch_en);
   wire logic blk = i_block;
   wire logic drop = ~pick_up | blk;

   ps_state_e state;
   ps_state_e next_state;
   logic [DW-1:0] op_cnt;
   logic [DW-1:0] next_op_cnt;
   logic [DW-1:0] rel_cnt;
   logic [DW-1:0] next_rel_cnt;
   logic blk_q;
   logic pick_q;
   wire logic rel_done = (rel_cnt + 1'b1 >= rel_dly);

   always_comb begin
      next_state = state;
      next_op_cnt = op_cnt;
      next_rel_cnt = rel_cnt;
      case (state)
         PS_NORMAL: begin
            if (pick_up && blk) begin
               next_state = PS_BLOCKED;
            end else if (pick_up) begin
               next_state = PS_START;
               next_op_cnt = op_dly;
               next_rel_cnt = '0;
            end
         end
         PS_START: begin
            if (drop) begin
               // Operate timing freezes while releasing so a blocked start cannot trip
               next_rel_cnt = rel_cnt + 1'b1;
               if (rel_done) begin
                  next_state = (pick_up && blk) ? PS_BLOCKED : PS_NORMAL;
                  next_op_cnt = '0;
                  next_rel_cnt = '0;
               end
            end else begin
               next_rel_cnt = '0;
               if (op_cnt <= DW'(1)) begin
                  next_state = PS_TRIP;
                  next_op_cnt = '0;
               end else begin
                  next_op_cnt = op_cnt - 1'b1;
               end
            end
         end
         PS_TRIP: begin
            if (drop) begin
               next_rel_cnt = rel_cnt + 1'b1;
               if (rel_done) begin
                  next_state = (pick_up && blk) ? PS_BLOCKED : PS_NORMAL;
                  next_rel_cnt = '0;
               end
            end else begin
               next_rel_cnt = '0;
            end
         end
         PS_BLOCKED: begin
            if (!pick_up) begin
               next_state = PS_NORMAL;
            end else if (!blk) begin
               next_state = PS_START;
               next_op_cnt = op_dly;
            end
         end
         default: begin
            next_state = PS_NORMAL;
            next_op_cnt = '0;
            next_rel_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge nrst) begin
      if (!nrst) begin
         state <= PS_NORMAL;
         op_cnt <= '0;
         rel_cnt <= '0;
         blk_q <= 1'b0;
         pick_q <= 1'b0;
      end else if (tick) begin
         state <= next_state;
         op_cnt <= next_op_cnt;
         rel_cnt <= next_rel_cnt;
         blk_q <= blk;
         pick_q <= pick_up;
      end
   end

   // Start is masked by the sampled block at once, even while release still runs
   wire logic started = (state == PS_START || state == PS_TRIP);
   assign o_start = started & ~blk_q;
   assign o_trip = (state == PS_TRIP);
   assign o_blocked = (state == PS_BLOCKED) || (pick_q && blk_q);

   // Reported condition: 0 normal, 1 start, 2 trip, 3 blocked
   wire logic [1:0] cond_code = o_trip ? 2'h2 : o_start ? 2'h1 : o_blocked ? 2'h3 : 2'h0;
   wire logic [DW-1:0] trem = (state == PS_START) ? op_cnt : '0;

   // Register read port; data stands for exactly one cycle after the strobe
   wire logic [4:0] sc_off = i_addr - `PS_A_SCALED0;
   wire logic [4:0] ra_off = i_addr - `PS_A_RATIO0;
   logic [W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (i_addr)
         `PS_A_CTRL: rd_mux = W'(meas_cnt);
         `PS_A_MODE: rd_mux = W'(mode_reg);
         `PS_A_OPDLY: rd_mux = W'(op_dly);
         `PS_A_RELDLY: rd_mux = W'(rel_dly);
         `PS_A_BLIM: rd_mux = blim;
         `PS_A_STATUS: begin
            rd_mux[1:0] = cond_code;
            rd_mux[`PS_STAT_BLK_BIT] = blk_q;
            rd_mux[`PS_STAT_PICK_BIT] = pick_q;
         end
         `PS_A_TREM: rd_mux = W'(trem);
         `PS_A_RCALC: rd_mux = ratio_calc;
         default: begin
            if (mult_off < 5'(NCH)) rd_mux = mult[mult_off[1:0]];
            else if (pick_off < 5'(NCH)) rd_mux = pick[pick_off[1:0]];
            else if (hyst_off < 5'(NCH)) rd_mux = hyst[hyst_off[1:0]];
            else if (sc_off < 5'(NCH)) rd_mux = scaled[sc_off[1:0]];
            else if (ra_off < 5'(NCH)) rd_mux = ratio_q[ra_off[1:0]];
            else rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge nrst) begin
      if (!nrst) o_rdata <= '0;
      else o_rdata <= i_rd ? rd_mux : '0;
   end
endmodule // ps_stage
`default_nettype wire

// file: ps_stage_sva.sv
// Port-level checks on the programmable stage
`default_nettype none
module ps_stage_sva #(
   parameter int W = 32,
   parameter int PROG_CYCLES = 8
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rd,
   input wire logic i_block,
   input wire logic [W-1:0] o_rdata,
   input wire logic o_start,
   input wire logic o_trip,
   input wire logic o_blocked,
   input wire logic o_prog_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap;
   logic seen;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (o_prog_tick) begin
         gap <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside answer cycle");
   tick_period_a: assert property (seen |-> o_prog_tick == (gap == PROG_CYCLES - 1))
      else $error("program tick period wrong");
   out_hold_a: assert property (!$past(o_prog_tick) |-> $stable({o_start, o_trip, o_blocked}))
      else $error("outputs moved between ticks");
   start_unblk_a: assert property ($past(o_prog_tick) && $past(i_block) |-> !o_start)
      else $error("start while block sampled");
   start_cause_a: assert property ($rose(o_start) |-> $past(o_prog_tick) && !$past(i_block))
      else $error("start rose without unblocked tick");
   blk_cause_a: assert property ($past(o_prog_tick) && !$past(i_block) |-> !o_blocked)
      else $error("blocked without block sample");
   start_excl_a: assert property (o_start |-> !o_blocked)
      else $error("start and blocked together");
   trip_cause_a: assert property ($rose(o_trip) |-> o_start && $past(o_prog_tick))
      else $error("trip rose outside started tick");
endmodule // ps_stage_sva
`default_nettype wire

// file: ps_meas_src.sv
// Measurement chain and blocking matrix model feeding the stage
`default_nettype none
module ps_meas_src (
   input wire logic i_clk,
   input wire logic i_tick,
   input wire logic signed [31:0] i_req_1,
   input wire logic signed [31:0] i_req_2,
   input wire logic signed [31:0] i_req_3,
   input wire logic i_req_blk,
   output logic signed [31:0] o_meas_1,
   output logic signed [31:0] o_meas_2,
   output logic signed [31:0] o_meas_3,
   output logic o_block
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_meas_1 = '0;
      o_meas_2 = '0;
      o_meas_3 = '0;
      o_block = 1'b0;
   end
   // New values land right after a tick, a full program cycle before they are used
   always @(posedge i_clk) begin
      if (i_tick) begin
         o_meas_1 <= i_req_1;
         o_meas_2 <= i_req_2;
         o_meas_3 <= i_req_3;
         o_block <= i_req_blk;
      end
   end
endmodule // ps_meas_src
`default_nettype wire

// file: programmable_threshold_stage_bench.sv
// Self-checking bench for the programmable stage
`include "ps_defines.svh"
`default_nettype none
module programmable_threshold_stage_bench import ps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 8;
   localparam int BLIM = 20;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [4:0] i_addr = '0;
   logic [31:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic signed [31:0] meas_1, meas_2, meas_3;
   logic signed [31:0] req_1 = '0, req_2 = '0, req_3 = '0;
   logic req_blk = 1'b0;
   logic i_block, o_start, o_trip, o_blocked, o_prog_tick;
   int n_errors = 0;
   int tests_run = 0;
   integer seed = 32'h0854;
   always #12.5 i_clk = ~i_clk;
   ps_stage #(.PROG_CYCLES(PC)) ps_stage_inst (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_meas_1(meas_1), .i_meas_2(meas_2), .i_meas_3(meas_3), .i_block(i_block),
      .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_prog_tick(o_prog_tick));
   ps_meas_src ps_meas_src_inst (.i_clk(i_clk), .i_tick(o_prog_tick), .i_req_1(req_1),
      .i_req_2(req_2), .i_req_3(req_3), .i_req_blk(req_blk), .o_meas_1(meas_1),
      .o_meas_2(meas_2), .o_meas_3(meas_3), .o_block(i_block));
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check_w(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_b(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s is %b", $time, what, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      check_w(d, e);
   endtask
   // Returns one cycle after the n-th tick, when the stage outputs have settled
   task automatic step(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge i_clk);
            #1;
            k++;
         end while (o_prog_tick !== 1'b1 && k < 2 * PC);
         if (o_prog_tick !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t no program tick", $time);
            close_out();
         end
         @(posedge i_clk);
         #1;
      end
   endtask
   function automatic longint ab(input longint v);
      return v < 0 ? -v : v;
   endfunction
   function automatic logic cond(input int m, input int pk, input int od, input int nw);
      longint thr;
      thr = ab(od) * ab(pk) / 1000000;
      case (m)
         0: return nw > pk;
         1: return ab(nw) > pk;
         2: return nw < pk && nw >= BLIM;
         3: return ab(nw) < pk && ab(nw) >= BLIM;
         4: return pk >= 0 ? nw - od > thr : od - nw > thr;
         5: return ab(nw - od) > thr;
         6: return pk >= 0 ? nw - od > pk : od - nw > -pk;
         default: return ab(nw - od) > pk;
      endcase
   endfunction
   // History is held six ticks so the 20 ms change modes see the old value
   task automatic mcase(input int m, input int pk, input int od, input int nw);
      logic [31:0] d;
      wr(`PS_A_MODE, 32'(m));
      wr(`PS_A_PICK0, 32'(pk));
      req_1 <= od;
      step(6);
      req_1 <= nw;
      step(2);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], cond(m, pk, od, nw), "pick-up");
   endtask
   initial begin
      logic [31:0] d;
      logic [31:0] rv [14];
      int m;
      rv = '{`PS_CTRL_RST, `PS_MODE_RST, `PS_OPDLY_RST, `PS_RELDLY_RST, `PS_BLIM_RST,
         `PS_MULT_RST, `PS_MULT_RST, `PS_MULT_RST, `PS_PICK_RST, `PS_PICK_RST,
         `PS_PICK_RST, `PS_HYST_RST, `PS_HYST_RST, `PS_HYST_RST};
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int a = 0; a < 14; a++) rchk(5'(a), rv[a]);
      wr(5'h0e, 32'hffff_ffff);
      rchk(5'h0e, 32'h0000_0000);
      rchk(5'h1f, 32'h0000_0000);
      wr(`PS_A_OPDLY, 32'h0007_0000);
      rchk(`PS_A_OPDLY, 32'(`PS_DLY_MAX));
      wr(`PS_A_HYST0, 32'h0000_0000);
      wr(`PS_A_BLIM, 32'(BLIM));
      mcase(0, 100, 0, 100);
      mcase(0, 100, 0, 101);
      mcase(0, -50, 0, -49);
      mcase(1, 100, 0, -101);
      mcase(2, 100, 0, 19);
      mcase(2, 100, 0, 20);
      mcase(3, 100, 0, -50);
      mcase(3, 100, 0, -19);
      mcase(4, 100000, 10000, 11001);
      mcase(4, -100000, 10000, 8999);
      mcase(5, 100000, 10000, 8999);
      mcase(5, 100000, 10000, 10500);
      mcase(6, 500, 0, -600);
      mcase(6, -500, 0, -501);
      mcase(7, 500, 0, -501);
      repeat (16) begin
         m = {$random(seed)} % 8;
         if (m == 4 || m == 5) m += 2;
         mcase(m, {$random(seed)} % 1000 + 1, $random(seed) % 2000, $random(seed) % 2000);
      end
      wr(`PS_A_MODE, 32'h0000_0000);
      wr(`PS_A_PICK0, 32'h0000_0064);
      wr(`PS_A_PICK0 + 5'h01, 32'h0000_0064);
      req_1 <= 0;
      req_2 <= 500;
      wr(`PS_A_CTRL, 32'h0000_0002);
      step(3);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], 1'b1, "second channel");
      wr(`PS_A_CTRL, 32'h0000_0000);
      rchk(`PS_A_CTRL, 32'h0000_0002);
      wr(`PS_A_CTRL, 32'h0000_0001);
      req_2 <= 0;
      req_3 <= 500;
      step(3);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], 1'b0, "one channel");
      wr(`PS_A_CTRL, 32'h0000_0003);
      step(2);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], 1'b1, "third channel");
      wr(`PS_A_CTRL, 32'h0000_0001);
      wr(`PS_A_HYST0, 32'h0000_7530);
      req_1 <= 101;
      step(2);
      req_1 <= 98;
      step(2);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], 1'b1, "hysteresis hold");
      req_1 <= 96;
      step(2);
      rd(`PS_A_STATUS, d);
      check_b(d[`PS_STAT_PICK_BIT], 1'b0, "hysteresis release");
      req_1 <= 0;
      wr(`PS_A_OPDLY, 32'h0000_0002);
      wr(`PS_A_RELDLY, 32'h0000_0002);
      wr(`PS_A_MULT0, 32'h0002_0000);
      step(6);
      req_1 <= 100;
      step(2);
      check_b(o_start, 1'b1, "start");
      rchk(`PS_A_TREM, 32'h0000_0002);
      rchk(`PS_A_SCALED0, 32'h0000_00c8);
      rchk(`PS_A_RATIO0, 32'h0002_0000);
      step(1);
      rchk(`PS_A_TREM, 32'h0000_0001);
      rchk(`PS_A_RCALC, 32'h0002_0000);
      check_b(o_trip, 1'b0, "trip early");
      step(1);
      check_b(o_trip, 1'b1, "trip");
      req_1 <= 0;
      step(2);
      check_b(o_start, 1'b1, "start held");
      check_b(o_trip, 1'b1, "trip held");
      step(1);
      check_b(o_start, 1'b0, "start released");
      check_b(o_trip, 1'b0, "trip released");
      req_blk <= 1'b1;
      req_1 <= 100;
      step(2);
      check_b(o_blocked, 1'b1, "blocked");
      check_b(o_start, 1'b0, "start blocked");
      rchk(`PS_A_STATUS, 32'h0000_0033);
      req_blk <= 1'b0;
      step(2);
      check_b(o_start, 1'b1, "start unblocked");
      check_b(o_blocked, 1'b0, "block cleared");
      req_blk <= 1'b1;
      step(2);
      check_b(o_start, 1'b0, "start dropped");
      step(2);
      check_b(o_trip, 1'b0, "no trip");
      rchk(`PS_A_STATUS, 32'h0000_0033);
      req_blk <= 1'b0;
      req_1 <= 0;
      step(3);
      check_b(o_blocked, 1'b0, "normal again");
      close_out();
   end
endmodule // programmable_threshold_stage_bench
bind ps_stage ps_stage_sva #(.W(W), .PROG_CYCLES(PROG_CYCLES)) ps_stage_sva_inst (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_block(i_block), .o_rdata(o_rdata),
   .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_prog_tick(o_prog_tick));
`default_nettype wire
